// ### hw/flash_ctl_regs.svh
// Addresses, field codes and reset values of the flash control logic.
// Assumes a 16-bit byte address bus and 8-bit data.
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

// Memory map
`define FLASH_CTRL_ADDR 16'hFE08
`define PROTECT_ADDR 16'hFF80
`define USER_LO 16'hB000
`define USER_HI 16'hFDFF
`define VECTOR_LO 16'hFFDC
`define VECTOR_HI 16'hFFFF
`define UPPER_LO 16'hC000
`define LOWER_HI 16'hBFFF

// Block protect bits: bit 3 guards the upper part, bits 2..0 guard all
`define PROTECT_UPPER_BIT 3
`define PROTECT_ALL_MASK 8'h07
`define PROTECT_UPPER_LO 16'hC000
`define PROTECT_ALL_LO 16'hB000

// Block size selection codes
`define SIZE_FULL 2'h0
`define SIZE_PART 2'h1
`define SIZE_EIGHT_ROWS 2'h2
`define SIZE_ONE_ROW 2'h3

// Address bit that picks the upper or lower part in the part-array case
`define PART_SELECT_BIT 14

// Pump divider codes and the matching terminal counts
`define DIV_BY_ONE 2'h0
`define DIV_BY_TWO_A 2'h1
`define DIV_BY_TWO_B 2'h2
`define DIV_BY_FOUR 2'h3
`define DIV_LIMIT_ONE 2'h0
`define DIV_LIMIT_TWO 2'h1
`define DIV_LIMIT_FOUR 2'h3

// Pump clock the divider should land near, and the bus clock rate
`define PUMP_TARGET_KHZ 2000
`define CLK_SYS_KHZ 100000

// Reset value of the control register
`define CTRL_RESET 8'h00

`endif

// ### hw/flash_ctl_pkg.sv
// Types shared by the flash control logic and its pump clock divider.
// Field codes come from flash_ctl_regs.svh; the field layouts are defined here.
package flash_ctl_pkg;

	// Setup sequence of a program or erase operation
	typedef enum logic [1:0] {
		seq_idle,
		seq_selected,
		seq_protect_read,
		seq_latched
	} seq_t;

	// Control register byte, bit 7 first
	typedef struct packed {
		logic [1:0] pump_divider_field;
		logic [1:0] erase_size_sel;
		logic high_voltage_enable;
		logic margin_select;
		logic erase_select;
		logic program_select;
	} flash_ctrl_t;

	// Block handed to the array for erase
	typedef struct packed {
		logic [15:0] lo;
		logic [15:0] hi;
		logic vectors;
	} erase_range_t;

	// One bus cycle from the processor
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	// Whole state of the control logic
	typedef struct packed {
		flash_ctrl_t ctrl;
		seq_t seq;
		logic [7:0] protect;
		logic [15:0] latched_addr;
		erase_range_t range;
		logic [7:0] rdata;
	} ctl_state_t;

	// Whole state of the pump divider
	typedef struct packed {
		logic [1:0] count;
		logic tick;
	} div_state_t;

endpackage : flash_ctl_pkg

// ### hw/pump_clock_divider.sv
// Divides the bus clock into a one-cycle pump clock enable.
// Assumes the select input comes from a register on the same clock.
`timescale 1ns/1ns
`include "flash_ctl_regs.svh"

module pump_clock_divider
	import flash_ctl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic [1:0] div_sel,
	output logic pump_tick
);

	div_state_t state;
	div_state_t next_state;
	logic [1:0] limit;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Terminal count; both middle codes divide by two
	always_comb begin
		case (div_sel)
			`DIV_BY_ONE: limit = `DIV_LIMIT_ONE;
			`DIV_BY_TWO_A: limit = `DIV_LIMIT_TWO;
			`DIV_BY_TWO_B: limit = `DIV_LIMIT_TWO;
			default: limit = `DIV_LIMIT_FOUR;
		endcase
	end

	// Compare with >= so a smaller divisor chosen mid-count cannot stall
	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (!enable) begin
			next_state.count = 2'h0;
		end else if (state.count >= limit) begin
			next_state.count = 2'h0;
			next_state.tick = 1'b1;
		end else begin
			next_state.count = state.count + 2'h1;
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pump_tick = state.tick;

	a_div_by_one: assert property (enable && div_sel == `DIV_BY_ONE |=> pump_tick)
		else $error("pump tick missing at divide by one");
	a_div_by_four: assert property (
		pump_tick && enable && div_sel == `DIV_BY_FOUR ##1 (enable && div_sel == `DIV_BY_FOUR) [*3]
		|-> !pump_tick && !$past(pump_tick) && !$past(pump_tick, 2) ##1 pump_tick)
		else $error("pump tick spacing wrong at divide by four");

endmodule : pump_clock_divider

// ### hw/flash_erase_ctl.sv
// Flash control logic: control register, setup interlocks, protect check,
// erase block decode and pump clock enable.
// Assumes the array answers reads combinationally on array_rdata in the
// cycle of the read strobe, and that one bus master drives bus.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`include "flash_ctl_regs.svh"

module flash_erase_ctl
	import flash_ctl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input bus_req_t bus,
	input wire logic [7:0] array_rdata,
	output logic [7:0] rdata,
	output logic pump_tick,
	output logic erase_hv,
	output logic program_hv,
	output logic margin_select,
	output erase_range_t erase_range
);

	ctl_state_t state;
	ctl_state_t next_state;
	flash_ctrl_t wctrl;
	erase_range_t new_range;
	logic next_erase;
	logic next_program;
	logic ctrl_write;
	logic flash_write;
	logic protect_read;
	logic overlap;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// User space or vector space of the array
	function automatic logic in_flash(input logic [15:0] a);
		in_flash = (a >= `USER_LO && a <= `USER_HI) || a >= `VECTOR_LO;
	endfunction : in_flash

	// Block to erase from the latched address and the size bits
	function automatic erase_range_t decode_range(input logic [15:0] a, input logic [1:0] sz);
		erase_range_t r;
		r.vectors = 1'b0;
		r.lo = `USER_LO;
		r.hi = `USER_HI;
		case (sz)
			`SIZE_FULL: begin
				r.vectors = 1'b1;
			end
			`SIZE_PART: begin
				if (a[`PART_SELECT_BIT]) begin
					r.lo = `UPPER_LO;
					r.vectors = 1'b1;
				end else begin
					r.hi = `LOWER_HI;
				end
			end
			`SIZE_EIGHT_ROWS: begin
				r.lo = {a[15:9], 9'h000};
				r.hi = {a[15:9], 9'h1FF};
			end
			default: begin
				r.lo = {a[15:6], 6'h00};
				r.hi = {a[15:6], 6'h3F};
			end
		endcase
		decode_range = r;
	endfunction : decode_range

	// Every guarded area runs to the top of memory, so only the top end matters
	function automatic logic hits_protect(input erase_range_t r, input logic [7:0] p);
		logic [15:0] top;
		top = r.vectors ? `VECTOR_HI : r.hi;
		if ((p & `PROTECT_ALL_MASK) != 8'h00) begin
			hits_protect = top >= `PROTECT_ALL_LO;
		end else if (p[`PROTECT_UPPER_BIT]) begin
			hits_protect = top >= `PROTECT_UPPER_LO;
		end else begin
			hits_protect = 1'b0;
		end
	endfunction : hits_protect

	// Decode of the bus cycle
	assign wctrl = flash_ctrl_t'(bus.wdata);
	assign ctrl_write = bus.wr && bus.addr == `FLASH_CTRL_ADDR;
	assign flash_write = bus.wr && in_flash(bus.addr);
	assign protect_read = bus.rd && bus.addr == `PROTECT_ADDR;
	assign new_range = decode_range(bus.addr, state.ctrl.erase_size_sel);
	assign overlap = hits_protect(new_range, state.protect);

	// Select bits from a control write; a write setting both leaves both
	always_comb begin
		next_erase = state.ctrl.erase_select;
		next_program = state.ctrl.program_select;
		if (!(wctrl.erase_select && wctrl.program_select)) begin
			next_erase = wctrl.erase_select;
			next_program = wctrl.program_select;
		end
	end

	// Next state of the whole block
	always_comb begin
		next_state = state;
		next_state.rdata = 8'h00;

		// Read data stand only in the cycle after the strobe
		if (bus.rd) begin
			if (bus.addr == `FLASH_CTRL_ADDR) begin
				next_state.rdata = state.ctrl;
			end else if (in_flash(bus.addr) || protect_read) begin
				next_state.rdata = array_rdata;
			end
		end

		// Protect byte is caught only once an operation is selected
		if (protect_read && state.seq == seq_selected && !state.ctrl.high_voltage_enable) begin
			next_state.protect = array_rdata;
			next_state.seq = seq_protect_read;
		end

		// Any data to a flash address fixes the block and checks protection
		if (flash_write && state.seq == seq_protect_read && !state.ctrl.high_voltage_enable) begin
			next_state.latched_addr = bus.addr;
			next_state.range = new_range;
			if (overlap) begin
				next_state.ctrl.erase_select = 1'b0;
				next_state.ctrl.program_select = 1'b0;
				next_state.seq = seq_idle;
			end else begin
				next_state.seq = seq_latched;
			end
		end

		if (ctrl_write) begin
			// Size and divider stay frozen once a block is latched
			if (state.seq != seq_latched) begin
				next_state.ctrl.pump_divider_field = wctrl.pump_divider_field;
				next_state.ctrl.erase_size_sel = wctrl.erase_size_sel;
			end
			next_state.ctrl.erase_select = next_erase;
			next_state.ctrl.program_select = next_program;
			if (!next_erase && !next_program) begin
				next_state.seq = seq_idle;
			end else if ((next_erase && !state.ctrl.erase_select)
				|| (next_program && !state.ctrl.program_select)) begin
				next_state.seq = seq_selected;
			end
			// Enable is honoured only at the end of a complete setup
			if (wctrl.high_voltage_enable) begin
				if (state.seq == seq_latched && (next_erase || next_program)) begin
					next_state.ctrl.high_voltage_enable = 1'b1;
				end
			end else begin
				next_state.ctrl.high_voltage_enable = 1'b0;
			end
			// Dropping the operation also drops the high voltage
			if (!next_erase && !next_program) begin
				next_state.ctrl.high_voltage_enable = 1'b0;
			end
			// Margin read cannot coexist with high voltage
			next_state.ctrl.margin_select = wctrl.margin_select
				&& !next_state.ctrl.high_voltage_enable;
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Pump runs only while high voltage is requested
	pump_clock_divider u_pump_div (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.enable(state.ctrl.high_voltage_enable),
		.div_sel(state.ctrl.pump_divider_field),
		.pump_tick(pump_tick)
	);

	// Array control; the array drives erased cells to zero
	assign erase_hv = state.ctrl.high_voltage_enable && state.ctrl.erase_select;
	assign program_hv = state.ctrl.high_voltage_enable && state.ctrl.program_select;
	assign margin_select = state.ctrl.margin_select;
	assign erase_range = state.range;
	assign rdata = state.rdata;

	a_select_interlock: assert property (!(state.ctrl.erase_select && state.ctrl.program_select))
		else $error("program and erase select both set");

	a_hv_after_setup: assert property ($rose(state.ctrl.high_voltage_enable)
		|-> $past(state.seq) == seq_latched && (erase_hv || program_hv))
		else $error("high voltage set without full setup");

	a_latch_address: assert property (
		flash_write && state.seq == seq_protect_read && !state.ctrl.high_voltage_enable
		|=> state.latched_addr == $past(bus.addr) && state.seq != seq_protect_read)
		else $error("erase address not latched");

	a_protect_clears: assert property (
		flash_write && state.seq == seq_protect_read && !state.ctrl.high_voltage_enable && overlap
		|=> !state.ctrl.erase_select && !state.ctrl.program_select ##1 !erase_hv)
		else $error("protected block did not clear select");

	a_full_array: assert property (
		erase_hv && state.ctrl.erase_size_sel == `SIZE_FULL
		|-> erase_range.lo == `USER_LO && erase_range.hi == `USER_HI && erase_range.vectors)
		else $error("full array range wrong");

	a_upper_part: assert property (
		erase_hv && state.ctrl.erase_size_sel == `SIZE_PART && state.latched_addr[14]
		|-> erase_range.lo == `UPPER_LO && erase_range.hi == `USER_HI && erase_range.vectors)
		else $error("upper part range wrong");

	a_lower_part: assert property (
		erase_hv && state.ctrl.erase_size_sel == `SIZE_PART && !state.latched_addr[14]
		|-> erase_range.lo == `USER_LO && erase_range.hi == `LOWER_HI && !erase_range.vectors)
		else $error("lower part range wrong");

	a_eight_rows: assert property (
		erase_hv && state.ctrl.erase_size_sel == `SIZE_EIGHT_ROWS
		|-> erase_range.hi - erase_range.lo == 16'h01FF
		&& erase_range.lo[15:9] == state.latched_addr[15:9] && erase_range.lo[8:0] == 9'h000)
		else $error("eight row range wrong");

	a_single_row: assert property (
		erase_hv && state.ctrl.erase_size_sel == `SIZE_ONE_ROW
		|-> erase_range.hi - erase_range.lo == 16'h003F
		&& erase_range.lo[15:6] == state.latched_addr[15:6] && erase_range.lo[5:0] == 6'h00)
		else $error("single row range wrong");

	a_hv_stops: assert property (
		ctrl_write && !wctrl.high_voltage_enable
		|=> !erase_hv && !program_hv ##1 !pump_tick [*2])
		else $error("high voltage kept after clear");

	// Enable must always have an operation behind it
	a_hv_needs_select: assert property (
		state.ctrl.high_voltage_enable |-> state.ctrl.erase_select || state.ctrl.program_select)
		else $error("high voltage without a selected operation");

	// Enable cannot appear before the address is latched
	a_hv_held_off: assert property (
		state.seq != seq_latched && !state.ctrl.high_voltage_enable
		|=> !state.ctrl.high_voltage_enable)
		else $error("high voltage set before latch");

	// Margin and high voltage exclude each other
	a_margin_no_hv: assert property (margin_select |-> !state.ctrl.high_voltage_enable)
		else $error("margin set with high voltage");

	// Protect byte is caught on the read that follows selection
	a_protect_capture: assert property (
		protect_read && state.seq == seq_selected && !state.ctrl.high_voltage_enable
		|=> state.protect == $past(array_rdata) && state.seq == seq_protect_read)
		else $error("protect byte not captured");

	// Size bits cannot move under a latched block
	a_size_frozen: assert property (
		state.seq == seq_latched && ctrl_write
		|=> state.ctrl.erase_size_sel == $past(state.ctrl.erase_size_sel))
		else $error("size changed while latched");

	// Block handed to the array holds for the whole pulse
	a_range_held: assert property (
		erase_hv && $past(erase_hv) |-> $stable(erase_range))
		else $error("erase range moved during high voltage");

	// Pump stays quiet once enable has been low a cycle
	a_pump_idle: assert property (
		!state.ctrl.high_voltage_enable && !$past(state.ctrl.high_voltage_enable) |-> !pump_tick)
		else $error("pump tick without high voltage");

	// Read data are zero unless a read was taken the cycle before
	a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");

	a_erase_no_program: assert property (erase_hv |-> !program_hv && !margin_select)
		else $error("erase overlaps program or margin");

endmodule : flash_erase_ctl

// ### tb/flash_array_model.sv
// Behavioural flash array: byte reads, protect byte, erase of the latched block.
// Assumes one bus master and erase_hv driven by the control logic.
`timescale 1ns/1ns
`include "flash_ctl_regs.svh"
module flash_array_model
	import flash_ctl_pkg::*;
(
	input wire logic clk_sys,
	input bus_req_t bus,
	input wire logic erase_hv,
	input erase_range_t erase_range,
	input wire logic [7:0] protect_value,
	output logic [7:0] array_rdata
);
	bit erased [0:65535];
	logic hv_q = 1'b0;

	// Unerased cells give a nonzero pattern so a missed erase shows
	always_comb begin
		if (bus.addr == `PROTECT_ADDR)
			array_rdata = protect_value;
		else if (erased[bus.addr])
			array_rdata = 8'h00;
		else
			array_rdata = (bus.addr[7:0] ^ 8'h5A) | 8'h01;
	end

	// Marked once per pulse to keep the run short
	always @(posedge clk_sys) begin
		hv_q <= erase_hv;
		if (erase_hv && !hv_q) begin
			for (int i = 0; i < 65536; i++) begin
				if ((i >= erase_range.lo && i <= erase_range.hi) ||
						(erase_range.vectors && i >= `VECTOR_LO))
					erased[i] = 1'b1;
			end
		end
	end
endmodule : flash_array_model

// ### tb/tb_flash_pump_clock_and_block_erase.sv
// Self-checking bench for the flash erase control logic.
// Assumes the array model answers reads and tracks erased cells.
`timescale 1ns/1ns
`include "flash_ctl_regs.svh"
module tb_flash_pump_clock_and_block_erase
	import flash_ctl_pkg::*;
;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	bus_req_t bus = '0;
	logic [7:0] array_rdata, rdata;
	logic [7:0] protect_value = 8'h00;
	logic pump_tick, erase_hv, program_hv, margin_select;
	erase_range_t erase_range;
	int failures = 0;
	int tests_run = 0;
	int seed = 32'h2B09AB02;

	flash_erase_ctl flash_erase_ctl_inst (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.bus(bus),
		.array_rdata(array_rdata),
		.rdata(rdata),
		.pump_tick(pump_tick),
		.erase_hv(erase_hv),
		.program_hv(program_hv),
		.margin_select(margin_select),
		.erase_range(erase_range)
	);

	flash_array_model flash_array_model_inst (
		.clk_sys(clk_sys),
		.bus(bus),
		.erase_hv(erase_hv),
		.erase_range(erase_range),
		.protect_value(protect_value),
		.array_rdata(array_rdata)
	);

	// 100 MHz bus clock, well above the lowest erase rate
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_range(erase_range_t got, erase_range_t exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_range

	task automatic end_sim;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	// Bus cycles: strobe for one cycle, results looked at after the edge
	task automatic wr(logic [15:0] a, logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(logic [15:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task automatic count_ticks(output logic [7:0] n);
		n = 8'h00;
		repeat (8) begin
			@(posedge clk_sys);
			#1 n = n + 8'(pump_tick);
		end
	endtask : count_ticks

	function automatic erase_range_t exp_range(logic [1:0] sz, logic [15:0] a);
		case (sz)
			2'h0: return '{`USER_LO, `USER_HI, 1'b1};
			2'h1: return a[14] ? '{`UPPER_LO, `USER_HI, 1'b1} : '{`USER_LO, `LOWER_HI, 1'b0};
			2'h2: return '{{a[15:9], 9'h000}, {a[15:9], 9'h1FF}, 1'b0};
			default: return '{{a[15:6], 6'h00}, {a[15:6], 6'h3F}, 1'b0};
		endcase
	endfunction : exp_range

	// Pump ticks seen in eight cycles; every code is swept, software picks near 2 MHz
	// Supply taken below 3.6 V; regulator bit lives outside this block
	function automatic logic [7:0] exp_ticks(logic [1:0] dv);
		return (dv == 2'h0) ? 8'h08 : (dv == 2'h3) ? 8'h02 : 8'h04;
	endfunction : exp_ticks

	// One whole erase sequence, possibly refused by the protect byte
	task automatic erase_case(logic [1:0] sz, logic [1:0] dv, logic [15:0] a, logic [7:0] prot);
		logic [7:0] d;
		logic blk;
		erase_range_t er;
		er = exp_range(sz, a);
		blk = (prot[2:0] != 3'h0) || (prot[3] && (er.vectors || er.hi >= `UPPER_LO));
		protect_value <= prot;
		wr(`FLASH_CTRL_ADDR, {dv, sz, 4'h2});
		rd(`PROTECT_ADDR, d);
		chk_byte(d, prot);
		wr(a, 8'($random(seed)));
		chk_range(erase_range, er);
		rd(`FLASH_CTRL_ADDR, d);
		chk_byte(d, {dv, sz, 2'h0, !blk, 1'b0});
		wr(`FLASH_CTRL_ADDR, {dv, sz, 4'hA});
		chk_byte({7'h0, erase_hv}, {7'h0, !blk});
		count_ticks(d);
		chk_byte(d, blk ? 8'h00 : exp_ticks(dv));
		wr(`FLASH_CTRL_ADDR, {dv, sz, 4'h2});
		chk_byte({7'h0, erase_hv}, 8'h00);
		count_ticks(d);
		chk_byte(d, 8'h00);
		wr(`FLASH_CTRL_ADDR, {dv, sz, 4'h0});
		repeat (4) @(posedge clk_sys);
		rd(a, d);
		if (!blk)
			chk_byte(d, 8'h00);
	endtask : erase_case

	// Cut a hang short
	initial begin
		#200000;
		failures++;
		end_sim();
	end

	// Main sequence
	initial begin
		logic [7:0] d;
		logic [15:0] a;
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1 chk_byte(rdata, 8'h00);
		chk_range(erase_range, '0);
		for (int i = 0; i < 16; i++) begin
			a = `USER_LO + 16'($unsigned($random(seed)) % 32'h4E00);
			erase_case(2'(i), 2'(i >> 2), a, 8'h00);
		end
		erase_case(2'h2, 2'h3, 16'hFB10, 8'h00);
		erase_case(2'h0, 2'h1, `VECTOR_LO, 8'h00);
		erase_case(2'h1, 2'h2, 16'hD123, 8'h08);
		erase_case(2'h1, 2'h0, 16'hB123, 8'h08);
		erase_case(2'h3, 2'h3, 16'hBC60, 8'h04);
		wr(`FLASH_CTRL_ADDR, 8'h08);
		chk_byte({7'h0, erase_hv}, 8'h00);
		wr(`FLASH_CTRL_ADDR, 8'h03);
		rd(`FLASH_CTRL_ADDR, d);
		chk_byte({6'h0, d[1:0]}, 8'h00);
		wr(`FLASH_CTRL_ADDR, 8'h02);
		wr(`FLASH_CTRL_ADDR, 8'h03);
		rd(`FLASH_CTRL_ADDR, d);
		chk_byte({6'h0, d[1:0]}, 8'h02);
		wr(`FLASH_CTRL_ADDR, 8'h04);
		chk_byte({7'h0, margin_select}, 8'h01);
		wr(`FLASH_CTRL_ADDR, 8'h00);
		chk_byte({7'h0, margin_select}, 8'h00);
		rd(16'h0040, d);
		chk_byte(d, 8'h00);
		@(posedge clk_sys);
		#1 chk_byte(rdata, 8'h00);
		chk_byte({7'h0, program_hv}, 8'h00);
		end_sim();
	end
endmodule : tb_flash_pump_clock_and_block_erase
